/* logic/cic_pkg.sv */
/*
 Package of the interrupt controller: register map, field positions, reset values,
 vectors and the carrier structs.
 Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
package cic_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CIC_CTRL_OFS = 8'h00;
  localparam logic [7:0] CIC_SENS_OFS = 8'h04;
  localparam logic [7:0] CIC_PEND_OFS = 8'h08;
  localparam logic [7:0] CIC_STAT_OFS = 8'h0C;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CIC_CTRL_MASK_BIT = 0;
  localparam int CIC_CTRL_PEN_LSB = 8;
  localparam int CIC_NUM_SRC = 14;
  localparam int CIC_NUM_EXT = 5;
  localparam logic CIC_MASK_RST = 1'b1;
  localparam logic [9:0] CIC_SENS_RST = 10'h000;
  localparam logic [4:0] CIC_PEN_RST = 5'h00;

  // Slot numbers
  localparam int CIC_SLOT_WAKE = 0;
  localparam int CIC_SLOT_EXT0 = 1;
  localparam int CIC_SLOT_EXT3 = 5;
  localparam int CIC_SLOT_EXT4 = 6;
  localparam int CIC_SLOT_SUPPLY = 7;
  localparam int CIC_SLOT_CMP = 8;
  localparam int CIC_SLOT_OVF = 9;
  localparam int CIC_SLOT_CAPT = 10;
  localparam int CIC_SLOT_RTB = 11;

  // ****************************************
  // Vectors
  // ****************************************
  localparam logic [15:0] CIC_VEC_RESET = 16'hFFFE;
  localparam logic [15:0] CIC_VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] CIC_VEC_SLOT0 = 16'hFFFA;

  // Valid slots and halt wake classes
  localparam logic [13:0] CIC_SLOT_USED = 14'h0FEF;
  localparam logic [13:0] CIC_WAKE_HALT = 14'h002E;
  localparam logic [13:0] CIC_WAKE_ACTIVE = 14'h0A6E;
  localparam logic [13:0] CIC_WAKE_AUTO = 14'h0001;

  typedef enum logic [1:0] {
    CIC_SENS_FALL_LOW = 2'b00,
    CIC_SENS_RISE = 2'b01,
    CIC_SENS_FALL = 2'b10,
    CIC_SENS_BOTH = 2'b11
  } cic_sens_e;

  typedef enum logic [2:0] {
    CIC_PWR_RUN = 3'b000,
    CIC_PWR_WAIT = 3'b001,
    CIC_PWR_HALT = 3'b010,
    CIC_PWR_ACTIVE_HALT = 3'b011,
    CIC_PWR_AUTO_HALT = 3'b100
  } cic_pwr_e;

  typedef enum logic [1:0] {
    CIC_ST_RUN = 2'b00,
    CIC_ST_STACK = 2'b01,
    CIC_ST_VECTOR = 2'b10
  } cic_state_e;

  // Core handshake carrier
  typedef struct packed {
    logic instr_done;
    logic trap;
    logic return_from_handler;
    logic stack_done;
    cic_pwr_e pwr_mode;
  } cic_core_s;

  typedef struct packed {
    logic stack_req;
    logic vector_valid;
    logic [15:0] vector;
    logic wake;
    logic condition_mask;
  } cic_resp_s;

endpackage

/* logic/cic_top.sv */
/*
 Interrupt controller of an 8-bit core: latches line and peripheral requests,
 picks the lowest-numbered pending slot at an instruction boundary and hands the core its vector.
 Assumes the core sequencer performs the register stacking when asked and pulses
 stack_done; peripheral flags arrive as levels on core_clk; lines come from pins.
*/
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module cic_top #(
  parameter int LINE4_WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [3:0] ext_line_pin,
  input wire logic [LINE4_WIDTH-1:0] line_four_pins,
  input wire logic [LINE4_WIDTH-1:0] line_four_input_en,
  input wire logic [8:0] periph_flag,
  input wire logic [8:0] periph_enable,
  input wire logic [8:0] periph_clear,
  input wire cic_pkg::cic_core_s core_in,
  output cic_pkg::cic_resp_s core_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cic_pkg::cic_state_e state;
    logic mask;
    logic [9:0] sens;
    logic [4:0] pen;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [LINE4_WIDTH-1:0] l4_sync1;
    logic [LINE4_WIDTH-1:0] l4_sync2;
    logic [4:0] prev;
    logic [13:0] pend;
    logic [13:0] flag_prev;
    logic trap_pend;
    logic trap_active;
    logic [3:0] sel;
    cic_pkg::cic_resp_s resp;
    logic [31:0] rdata;
    logic ack;
  } cic_state_s;

  cic_state_s cur_reg;
  cic_state_s cur_next;

  logic [4:0] line_lvl;
  logic [4:0] line_evt;
  logic [13:0] req;
  logic [13:0] wake_set;
  logic any_req;
  logic [3:0] win;
  logic bus_hit;
  logic wr_sens;
  logic [9:0] new_sens;
  logic [13:0] flag_now;

  // ****************************************
  // Line conditioning
  // ****************************************
  always_comb
  begin
    line_lvl = cur_reg.sync2;
    // Combined line: any enabled low input holds it low
    line_lvl[4] = &(cur_reg.l4_sync2 | ~line_four_input_en);
    for (int i = 0; i < cic_pkg::CIC_NUM_EXT; i++)
    begin
      case (cic_pkg::cic_sens_e'(cur_reg.sens[2*i +: 2]))
        cic_pkg::CIC_SENS_FALL_LOW: line_evt[i] = ~line_lvl[i];
        cic_pkg::CIC_SENS_RISE: line_evt[i] = line_lvl[i] & ~cur_reg.prev[i];
        cic_pkg::CIC_SENS_FALL: line_evt[i] = ~line_lvl[i] & cur_reg.prev[i];
        cic_pkg::CIC_SENS_BOTH: line_evt[i] = line_lvl[i] ^ cur_reg.prev[i];
        default: line_evt[i] = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Request and priority
  // ****************************************
  always_comb
  begin
    flag_now = '0;
    flag_now[cic_pkg::CIC_SLOT_WAKE] = periph_flag[0];
    flag_now[cic_pkg::CIC_SLOT_SUPPLY +: 5] = periph_flag[5:1];
    // Unused flags go to unused slots, never to line slots
    flag_now[4] = periph_flag[6];
    flag_now[13:12] = periph_flag[8:7];
    // Peripheral enables gate, mask gates all maskable slots
    req = cur_reg.pend & cic_pkg::CIC_SLOT_USED;
    req[cic_pkg::CIC_SLOT_WAKE] = req[cic_pkg::CIC_SLOT_WAKE] & periph_enable[0];
    for (int k = 0; k < 5; k++)
    begin
      req[cic_pkg::CIC_SLOT_SUPPLY + k] = req[cic_pkg::CIC_SLOT_SUPPLY + k] & periph_enable[k + 1];
    end
    for (int j = 0; j < cic_pkg::CIC_NUM_EXT; j++)
    begin
      if (j < 3)
      begin
        req[cic_pkg::CIC_SLOT_EXT0 + j] = req[cic_pkg::CIC_SLOT_EXT0 + j] & cur_reg.pen[j];
      end
      else
      begin
        req[cic_pkg::CIC_SLOT_EXT3 + j - 3] = req[cic_pkg::CIC_SLOT_EXT3 + j - 3] & cur_reg.pen[j];
      end
    end
    any_req = (|req) & ~cur_reg.mask;
    win = 4'h0;
    for (int s = cic_pkg::CIC_NUM_SRC - 1; s >= 0; s--)
    begin
      if (req[s])
      begin
        win = 4'(s);
      end
    end
    // Wake classes per power mode
    case (core_in.pwr_mode)
      cic_pkg::CIC_PWR_WAIT: wake_set = cic_pkg::CIC_SLOT_USED;
      cic_pkg::CIC_PWR_HALT: wake_set = cic_pkg::CIC_WAKE_HALT;
      cic_pkg::CIC_PWR_ACTIVE_HALT: wake_set = cic_pkg::CIC_WAKE_ACTIVE;
      cic_pkg::CIC_PWR_AUTO_HALT: wake_set = cic_pkg::CIC_WAKE_HALT | cic_pkg::CIC_WAKE_AUTO;
      default: wake_set = '0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    cur_next = cur_reg;
    // Raw pins pass two flops before the combining gate
    cur_next.sync1 = {1'b1, ext_line_pin};
    cur_next.l4_sync1 = line_four_pins;
    cur_next.l4_sync2 = cur_reg.l4_sync1;
    cur_next.sync2 = cur_reg.sync1;
    cur_next.prev = line_lvl;
    cur_next.flag_prev = flag_now;
    cur_next.ack = 1'b0;
    bus_hit = wb_cyc_i & wb_stb_i & ~cur_reg.ack;
    wr_sens = bus_hit & wb_we_i & (wb_adr_i[7:0] == cic_pkg::CIC_SENS_OFS) & wb_sel_i[0] & cur_reg.mask;
    new_sens = {wb_dat_i[9:8] & {2{wb_sel_i[1]}} | cur_reg.sens[9:8] & {2{~wb_sel_i[1]}}, wb_dat_i[7:0]};

    // Peripheral flag rise latches; clear sequence drops latch
    for (int p = 0; p < cic_pkg::CIC_NUM_SRC; p++)
    begin
      if (flag_now[p] & ~cur_reg.flag_prev[p])
      begin
        cur_next.pend[p] = 1'b1;
      end
    end
    for (int c = 0; c < 5; c++)
    begin
      if (periph_clear[c + 1] & ~(flag_now[cic_pkg::CIC_SLOT_SUPPLY + c] & ~cur_reg.flag_prev[cic_pkg::CIC_SLOT_SUPPLY + c]))
      begin
        cur_next.pend[cic_pkg::CIC_SLOT_SUPPLY + c] = 1'b0;
      end
    end
    if (periph_clear[0] & ~(flag_now[0] & ~cur_reg.flag_prev[0]))
    begin
      cur_next.pend[cic_pkg::CIC_SLOT_WAKE] = 1'b0;
    end

    // Line events latch regardless of mask
    for (int e = 0; e < cic_pkg::CIC_NUM_EXT; e++)
    begin
      if (wr_sens && (new_sens[2*e +: 2] != cur_reg.sens[2*e +: 2]))
      begin
        cur_next.pend[e < 3 ? cic_pkg::CIC_SLOT_EXT0 + e : cic_pkg::CIC_SLOT_EXT3 + e - 3] = 1'b0;
      end
      else if (line_evt[e])
      begin
        cur_next.pend[e < 3 ? cic_pkg::CIC_SLOT_EXT0 + e : cic_pkg::CIC_SLOT_EXT3 + e - 3] = 1'b1;
      end
    end
    cur_next.pend = cur_next.pend & cic_pkg::CIC_SLOT_USED;

    if (core_in.trap)
    begin
      cur_next.trap_pend = 1'b1;
    end
    cur_next.resp.wake = |(req & wake_set);
    cur_next.resp.vector_valid = 1'b0;

    // ****************************************
    // Entry sequence
    // ****************************************
    case (cur_reg.state)
      cic_pkg::CIC_ST_RUN:
      begin
        if (core_in.instr_done && (cur_reg.trap_pend || core_in.trap || any_req))
        begin
          cur_next.trap_active = cur_reg.trap_pend | core_in.trap;
          cur_next.trap_pend = 1'b0;
          cur_next.sel = win;
          cur_next.resp.stack_req = 1'b1;
          cur_next.state = cic_pkg::CIC_ST_STACK;
        end
        else if (core_in.return_from_handler)
        begin
          cur_next.mask = 1'b0;
        end
      end
      cic_pkg::CIC_ST_STACK:
      begin
        if (core_in.stack_done)
        begin
          cur_next.resp.stack_req = 1'b0;
          cur_next.mask = 1'b1;
          cur_next.resp.vector_valid = 1'b1;
          cur_next.resp.vector = cur_reg.trap_active ? cic_pkg::CIC_VEC_TRAP
                               : cic_pkg::CIC_VEC_SLOT0 - {11'h000, cur_reg.sel, 1'b0};
          if (!cur_reg.trap_active && !(line_evt != '0 && 1'b0))
          begin
            cur_next.pend[cur_reg.sel] = 1'b0;
          end
          cur_next.state = cic_pkg::CIC_ST_VECTOR;
        end
      end
      cic_pkg::CIC_ST_VECTOR:
      begin
        cur_next.state = cic_pkg::CIC_ST_RUN;
      end
      default:
      begin
        cur_next.state = cic_pkg::CIC_ST_RUN;
      end
    endcase
    cur_next.resp.condition_mask = cur_next.mask;

    // ****************************************
    // Wishbone slave
    // ****************************************
    if (bus_hit)
    begin
      cur_next.ack = 1'b1;
      cur_next.rdata = 32'h0000_0000;
      case (wb_adr_i[7:0])
        cic_pkg::CIC_CTRL_OFS:
        begin
          cur_next.rdata = {19'h00000, cur_reg.pen, 7'h00, cur_reg.mask};
          if (wb_we_i && wb_sel_i[0])
          begin
            cur_next.mask = wb_dat_i[cic_pkg::CIC_CTRL_MASK_BIT];
          end
          if (wb_we_i && wb_sel_i[1])
          begin
            cur_next.pen = wb_dat_i[cic_pkg::CIC_CTRL_PEN_LSB +: 5];
          end
        end
        cic_pkg::CIC_SENS_OFS:
        begin
          cur_next.rdata = {22'h000000, cur_reg.sens};
          if (wr_sens)
          begin
            cur_next.sens = new_sens;
          end
        end
        cic_pkg::CIC_PEND_OFS: cur_next.rdata = {18'h00000, cur_reg.pend};
        cic_pkg::CIC_STAT_OFS: cur_next.rdata = {26'h0000000, cur_reg.state, cur_reg.sel};
        default: cur_next.rdata = 32'h0000_0000;
      endcase
    end
    cur_next.resp.condition_mask = cur_next.mask;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur_reg <= '0;
      // Idle high, so no false edge follows reset
      cur_reg.sync1 <= '1;
      cur_reg.sync2 <= '1;
      cur_reg.prev <= '1;
      cur_reg.l4_sync1 <= '1;
      cur_reg.l4_sync2 <= '1;
      cur_reg.mask <= cic_pkg::CIC_MASK_RST;
      cur_reg.sens <= cic_pkg::CIC_SENS_RST;
      cur_reg.pen <= cic_pkg::CIC_PEN_RST;
      cur_reg.resp.condition_mask <= cic_pkg::CIC_MASK_RST;
      cur_reg.resp.vector <= cic_pkg::CIC_VEC_RESET;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  assign wb_dat_o = cur_reg.rdata;
  assign wb_ack_o = cur_reg.ack;
  assign core_out = cur_reg.resp;

endmodule

/* dv/cic_core_model.sv */
/*
 Core sequencer model: does the stacking when asked and answers with stack_done.
 Assumes the stacking request is a level held until stack_done.
*/
`timescale 1ns/1ps
module cic_core_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] lat,
  input wire logic stack_req,
  output logic stack_done
);
  int cnt;
  // Stacking of program counter, index, accumulator, condition code
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= 0;
      stack_done <= 1'b0;
    end
    else
    begin
      stack_done <= 1'b0;
      if (!stack_req)
        cnt <= 0;
      else if (cnt == int'(lat))
      begin
        stack_done <= 1'b1;
        cnt <= cnt + 1;
      end
      else if (cnt < int'(lat))
        cnt <= cnt + 1;
    end
  end
endmodule

/* dv/cic_top_assertions.sv */
/*
 Checker of the interrupt controller ports.
 Assumes it is bound to cic_top and sees only its ports.
*/
`timescale 1ns/1ps
module cic_top_assertions (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire cic_pkg::cic_core_s core_in,
  input wire cic_pkg::cic_resp_s core_out
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  a_mask_at_reset: assert property (!$past(arst_n) |-> core_out.condition_mask)
    else $error("mask clear after reset");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack in next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_entry_boundary: assert property ($rose(core_out.stack_req) |-> $past(core_in.instr_done))
    else $error("entry outside instruction end");
  a_stack_hold: assert property (core_out.stack_req && !core_in.stack_done |=> core_out.stack_req)
    else $error("stack request dropped early");
  a_vector_after: assert property (core_out.stack_req && core_in.stack_done |=>
    core_out.vector_valid && !core_out.stack_req)
    else $error("vector not after stacking");
  a_entry_mask: assert property (core_out.vector_valid |-> core_out.condition_mask)
    else $error("mask clear at entry");
  a_return_clears: assert property (core_in.return_from_handler |=> !core_out.condition_mask)
    else $error("mask set after return");
  a_unused_slot: assert property (core_out.vector_valid |->
    !(core_out.vector inside {16'hFFF2, 16'hFFE2, 16'hFFE0}))
    else $error("unused slot vectored");
endmodule
bind cic_top cic_top_assertions chk (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .core_in, .core_out);

/* dv/cic_top_bench.sv */
/*
 Bench of the interrupt controller: bus tasks, core pulses, vector checks.
 Assumes the core model in this folder and the checker bound to cic_top.
*/
`timescale 1ns/1ps
module cic_top_bench;
  logic core_clk;
  logic arst_n;
  logic [31:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_we_i;
  logic [3:0] wb_sel_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_ack_o;
  logic [3:0] ext_line_pin;
  logic [3:0] l4_pins;
  logic [3:0] l4_en;
  logic [8:0] pflag;
  logic [8:0] pen;
  logic [8:0] pclr;
  logic [3:0] lat;
  logic instr;
  logic trp;
  logic rfh;
  logic sdone;
  cic_pkg::cic_pwr_e pwr;
  cic_pkg::cic_core_s cin;
  cic_pkg::cic_resp_s cout;
  int error_cnt;
  int n_compared;
  logic [31:0] rd;
  int sl[6] = '{0, 7, 8, 9, 10, 11};
  cic_pkg::cic_pwr_e md[5] = '{cic_pkg::CIC_PWR_WAIT, cic_pkg::CIC_PWR_HALT,
    cic_pkg::CIC_PWR_ACTIVE_HALT, cic_pkg::CIC_PWR_AUTO_HALT, cic_pkg::CIC_PWR_HALT};
  int bt[5] = '{1, 3, 3, 0, 0};
  logic wk[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  assign cin = '{instr, trp, rfh, sdone, pwr};
  cic_top uut (.core_clk, .arst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .ext_line_pin, .line_four_pins(l4_pins), .line_four_input_en(l4_en),
    .periph_flag(pflag), .periph_enable(pen), .periph_clear(pclr), .core_in(cin), .core_out(cout));
  cic_core_model core (.core_clk, .arst_n, .lat, .stack_req(cout.stack_req), .stack_done(sdone));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ****
  // Tasks
  // ****
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task test_done;
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      error_cnt++;
      test_done;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {24'h000000, a};
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    tmo(wb_ack_o);
    rd = wb_dat_o;
    @(posedge core_clk);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task tick(input logic t);
    @(posedge core_clk);
    instr <= 1'b1;
    trp <= t;
    @(posedge core_clk);
    instr <= 1'b0;
    trp <= 1'b0;
  endtask
  task enter(input logic [15:0] v, input logic t);
    int k;
    tick(t);
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (cout.vector_valid !== 1'b1 && k < 50);
    tmo(cout.vector_valid);
    chk("vector", {16'h0000, cout.vector}, {16'h0000, v});
  endtask
  task quiet;
    logic seen;
    seen = 1'b0;
    tick(1'b0);
    repeat (6)
    begin
      @(negedge core_clk);
      seen = seen | cout.stack_req;
    end
    chk("no entry", {31'h0, seen}, 32'h0);
    @(posedge core_clk);
  endtask
  task leave;
    @(posedge core_clk);
    rfh <= 1'b1;
    @(posedge core_clk);
    rfh <= 1'b0;
  endtask
  task drop(input int i);
    @(posedge core_clk);
    pflag[i] <= 1'b0;
    pclr[i] <= 1'b1;
    @(posedge core_clk);
    pclr[i] <= 1'b0;
  endtask
  // ****
  // Sequence
  // ****
  initial
  begin
    {arst_n, wb_adr_i, wb_dat_i, wb_we_i, wb_sel_i, wb_cyc_i, wb_stb_i} = '0;
    {pflag, pen, pclr, lat, instr, trp, rfh} = '0;
    ext_line_pin = 4'h8;
    l4_pins = 4'hF;
    l4_en = 4'h0;
    pwr = cic_pkg::CIC_PWR_RUN;
    error_cnt = 0;
    n_compared = 0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd & 32'h1F01, 32'h1);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    pen <= 9'h03F;
    pflag[2] <= 1'b1;
    quiet;
    bus(1'b1, 8'h00, 32'h0);
    enter(16'hFFEA, 1'b0);
    drop(2);
    leave;
    lat <= 4'h3;
    pflag <= 9'h03F;
    for (int i = 0; i < 6; i++)
    begin
      enter(16'hFFFA - 16'(2 * sl[i]), 1'b0);
      drop(i);
      leave;
    end
    bus(1'b1, 8'h00, 32'h1);
    pen[4] <= 1'b0;
    pflag[4] <= 1'b1;
    @(posedge core_clk);
    drop(4);
    pen[4] <= 1'b1;
    bus(1'b1, 8'h00, 32'h0);
    quiet;
    bus(1'b1, 8'h00, 32'h1);
    enter(16'hFFFC, 1'b1);
    leave;
    bus(1'b1, 8'h00, 32'h0901);
    bus(1'b1, 8'h04, 32'h81);
    ext_line_pin <= 4'h1;
    repeat (4) @(posedge core_clk);
    bus(1'b1, 8'h00, 32'h0900);
    bus(1'b1, 8'h04, 32'h3FF);
    bus(1'b0, 8'h04, 32'h0);
    chk("sens", rd & 32'h3FF, 32'h81);
    enter(16'hFFF8, 1'b0);
    leave;
    enter(16'hFFF0, 1'b0);
    leave;
    quiet;
    for (int i = 0; i < 5; i++)
    begin
      pwr <= md[i];
      pflag[bt[i]] <= 1'b1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk("wake", {31'h0, cout.wake}, {31'h0, wk[i]});
      drop(bt[i]);
    end
    bus(1'b0, 8'h08, 32'h0);
    chk("line four idle", rd & 32'h40, 32'h0);
    l4_en <= 4'h1;
    l4_pins <= 4'hE;
    repeat (4) @(posedge core_clk);
    bus(1'b0, 8'h08, 32'h0);
    chk("line four low", rd & 32'h40, 32'h40);
    test_done;
  end
endmodule
